// *** spsc_top.sv ***
// supply control pin logic: straps, fault line, control, channels, registers
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "spsc_defs.svh"
module spsc_top
    import spsc_pkg::*;
    #(parameter int unsigned DGLT_CYC = `SPSC_DGLT_CYC)
    (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic IRQ,
    // block-side status inputs
    input wire logic [5:0] CHAN_FAULT,
    input wire logic [5:0] CHAN_ABOVE_PG_ON,
    input wire logic MEAS_CURRENT,
    input wire logic ALERT_REQ,
    // supply pins
    output logic [5:0] SUPPLY_ENABLE_OUT,
    output logic [5:0] SUPPLY_ENABLE_OE,
    output logic [5:0] MARGIN_DRIVE_OUT,
    output logic [5:0] MARGIN_DRIVE_OE,
    // fault line, control input, alert
    input wire logic FAULT_N_IN,
    output logic FAULT_N_OUT,
    output logic FAULT_N_OE,
    input wire logic CONTROL_IN,
    output logic ALERT_N_OUT,
    output logic ALERT_N_OE,
    // strap pins
    input wire logic ADDR_STRAP0_ANALOG_SEL_IN,
    output logic ADDR_STRAP0_ANALOG_SEL_OUT,
    output logic ADDR_STRAP0_ANALOG_SEL_OE,
    input wire logic ADDR_STRAP1_GOOD_OUT_IN,
    output logic ADDR_STRAP1_GOOD_OUT_OUT,
    output logic ADDR_STRAP1_GOOD_OUT_OE,
    output logic [1:0] BUS_ADDR,
    output logic PIN_PULLUP_EN
    );
    logic fault_dg;
    logic ctl_dg;
    logic ctl_dg_d;
    logic s0_meta;
    logic s0_sync;
    logic s1_meta;
    logic s1_sync;
    spsc_phase_t phase;
    spsc_phase_t next_phase;
    logic [2:0] scnt;
    logic [2:0] next_scnt;
    logic [1:0] next_addr;
    logic live;
    logic [9:0] ctrl;
    logic [9:0] next_ctrl;
    logic [5:0] group;
    logic [5:0] next_group;
    logic [7:0] stat;
    logic [7:0] next_stat;
    logic [7:0] mask;
    logic [7:0] next_mask;
    logic [21:0] mode;
    logic [21:0] next_mode;
    logic [6:0] duty [`SPSC_NCH];
    logic [6:0] next_duty [`SPSC_NCH];
    logic [31:0] next_rdata;
    logic next_irq;
    logic [7:0] ev;
    logic ctl_ok;
    logic pg_cond;
    logic [5:0] en_req;
    logic [5:0] div;
    logic [5:0] next_div;
    logic [5:0] step;
    logic [5:0] next_step;
    logic next_fault_oe;
    logic next_alert_oe;
    logic next_a0_out;
    logic next_a1_out;
    logic zero;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // -----------------------------------------------
    // pin filters
    // -----------------------------------------------
    spsc_dglt #(.DG(DGLT_CYC)) u_fault_dg ( // [RL11]
        .clk(CLK_SYS),
        .srst(SRST),
        .pin(FAULT_N_IN),
        .lvl(fault_dg)
    );
    spsc_dglt #(.DG(DGLT_CYC)) u_ctl_dg ( // [RL11]
        .clk(CLK_SYS),
        .srst(SRST),
        .pin(CONTROL_IN),
        .lvl(ctl_dg)
    );

    // -----------------------------------------------
    // strap sampling and pin turn-around
    // -----------------------------------------------
    always_comb begin
        next_phase = phase;
        next_scnt = scnt;
        next_addr = BUS_ADDR;
        unique case (phase)
            SPSC_HOLD: begin
                next_phase = SPSC_SAMPLE;
                next_scnt = '0;
            end
            SPSC_SAMPLE: begin
                // wait for the straps to pass the synchronisers before latching
                if (scnt == 3'(`SPSC_STRAP_CYC - 1)) begin
                    next_phase = SPSC_LIVE;
                    next_addr = {s1_sync, s0_sync}; // [RL5]
                end else begin
                    next_scnt = scnt + 1'b1;
                end
            end
            SPSC_LIVE: begin
                next_phase = SPSC_LIVE;
            end
            default: begin
                next_phase = SPSC_HOLD;
            end
        endcase
    end
    assign live = (phase == SPSC_LIVE);

    // -----------------------------------------------
    // supply control
    // -----------------------------------------------
    always_comb begin
        ctl_ok = !ctrl[`SPSC_CTRL_CTLUSE] || spsc_lvl(ctl_dg, ctrl[`SPSC_CTRL_CTLAH]); // [RL12]
        for (int i = 0; i < `SPSC_NCH; i++) begin
            // own fault, or the group line seen low, holds the supply off until cleared
            en_req[i] = ctrl[i] && ctl_ok && !stat[i]
                && !(group[i] && stat[`SPSC_STAT_GRP]); // [RL9]
        end
        pg_cond = (|en_req) && (&(CHAN_ABOVE_PG_ON | ~en_req)); // [RL13]
        ev = {ctl_dg != ctl_dg_d, !fault_dg, CHAN_FAULT};
        next_fault_oe = live && (|(stat[5:0] & group)); // [RL8] [RL10]
        next_alert_oe = live && ALERT_REQ; // [RL14]
        next_a0_out = live && MEAS_CURRENT; // [RL6] [RL7]
        next_a1_out = live && pg_cond; // [RL13]
        next_div = div + 1'b1;
        next_step = step;
        if (div == 6'(`SPSC_PWM_DIV - 1)) begin
            next_div = '0;
            next_step = step + 1'b1;
        end
    end

    // -----------------------------------------------
    // register port and interrupt
    // -----------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_group = group;
        next_mask = mask;
        next_mode = mode;
        next_duty = duty;
        next_rdata = '0;
        if (REG_WR && hit(REG_ADDR, `SPSC_OFF_CTRL)) next_ctrl = REG_WDATA[9:0];
        if (REG_WR && hit(REG_ADDR, `SPSC_OFF_GROUP)) next_group = REG_WDATA[5:0];
        if (REG_WR && hit(REG_ADDR, `SPSC_OFF_MASK)) next_mask = REG_WDATA[7:0];
        if (REG_WR && hit(REG_ADDR, `SPSC_OFF_MODE)) next_mode = REG_WDATA[21:0];
        // a new event beats a clear in the same cycle
        next_stat = ev | (stat & ~((REG_WR && hit(REG_ADDR, `SPSC_OFF_STAT)) ? REG_WDATA[7:0] : 8'h00));
        next_irq = |(next_stat & mask);
        for (int i = 0; i < `SPSC_NCH; i++) begin
            if (REG_WR && hit(REG_ADDR, 8'(`SPSC_OFF_DUTY0 + 4 * i))) next_duty[i] = REG_WDATA[6:0];
            if (REG_RD && hit(REG_ADDR, 8'(`SPSC_OFF_DUTY0 + 4 * i))) next_rdata = {25'h0, duty[i]};
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                `SPSC_OFF_CTRL: next_rdata = {22'h0, ctrl};
                `SPSC_OFF_GROUP: next_rdata = {26'h0, group};
                `SPSC_OFF_STAT: next_rdata = {24'h0, stat};
                `SPSC_OFF_MASK: next_rdata = {24'h0, mask};
                `SPSC_OFF_MODE: next_rdata = {10'h0, mode};
                `SPSC_OFF_PINS: next_rdata = {26'h0, live, pg_cond, fault_dg, ctl_dg, BUS_ADDR};
                default: next_rdata = next_rdata;
            endcase
        end
    end

    // -----------------------------------------------
    // registers
    // -----------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            phase <= SPSC_HOLD;
            scnt <= '0;
            BUS_ADDR <= 2'h0;
            s0_meta <= 1'b1;
            s0_sync <= 1'b1;
            s1_meta <= 1'b1;
            s1_sync <= 1'b1;
            ctl_dg_d <= 1'b1;
            ctrl <= `SPSC_RST_CTRL;
            group <= 6'h00;
            stat <= 8'h00;
            mask <= 8'h00;
            mode <= `SPSC_RST_MODE;
            for (int i = 0; i < `SPSC_NCH; i++) duty[i] <= 7'h00;
            REG_RDATA <= 32'h0;
            IRQ <= 1'b0;
            div <= 6'h00;
            step <= 6'h00;
            zero <= 1'b0;
            FAULT_N_OE <= 1'b0; // [RL10]
            ALERT_N_OE <= 1'b0;
            ADDR_STRAP0_ANALOG_SEL_OUT <= 1'b0;
            ADDR_STRAP0_ANALOG_SEL_OE <= 1'b0;
            ADDR_STRAP1_GOOD_OUT_OUT <= 1'b0;
            ADDR_STRAP1_GOOD_OUT_OE <= 1'b0;
            PIN_PULLUP_EN <= 1'b1; // [RL15]
        end else begin
            phase <= next_phase;
            scnt <= next_scnt;
            BUS_ADDR <= next_addr;
            s0_meta <= ADDR_STRAP0_ANALOG_SEL_IN;
            s0_sync <= s0_meta;
            s1_meta <= ADDR_STRAP1_GOOD_OUT_IN;
            s1_sync <= s1_meta;
            ctl_dg_d <= ctl_dg;
            ctrl <= next_ctrl;
            group <= next_group;
            stat <= next_stat;
            mask <= next_mask;
            mode <= next_mode;
            duty <= next_duty;
            REG_RDATA <= next_rdata;
            IRQ <= next_irq;
            div <= next_div;
            step <= next_step;
            zero <= 1'b0;
            FAULT_N_OE <= next_fault_oe;
            ALERT_N_OE <= next_alert_oe;
            ADDR_STRAP0_ANALOG_SEL_OUT <= next_a0_out;
            ADDR_STRAP0_ANALOG_SEL_OE <= live; // [RL6]
            ADDR_STRAP1_GOOD_OUT_OUT <= next_a1_out;
            ADDR_STRAP1_GOOD_OUT_OE <= live; // [RL13]
            PIN_PULLUP_EN <= !live; // [RL15]
        end
    end
    // open-drain lines only ever drive low
    assign FAULT_N_OUT = zero;
    assign ALERT_N_OUT = zero;

    // -----------------------------------------------
    // channels
    // -----------------------------------------------
    for (genvar g = 0; g < `SPSC_NCH; g++) begin : g_ch
        spsc_chan u_ch ( // [RL16]
            .clk(CLK_SYS),
            .srst(SRST),
            .live(live),
            .en_req(en_req[g]),
            .act_high(mode[`SPSC_MODE_AH + g]),
            .open_drain(mode[`SPSC_MODE_OD + g]),
            .margin_en(mode[`SPSC_MODE_MEN + g]),
            .duty(duty[g]),
            .step(step),
            .en_out(SUPPLY_ENABLE_OUT[g]),
            .en_oe(SUPPLY_ENABLE_OE[g]),
            .mg_out(MARGIN_DRIVE_OUT[g]),
            .mg_oe(MARGIN_DRIVE_OE[g])
        );
    end

    // -----------------------------------------------
    // checks
    // -----------------------------------------------
    AST_STRAP_LATCH: assert property (@(posedge CLK_SYS) disable iff (SRST) // [RL5]
        live && $past(live) |-> $stable(BUS_ADDR))
        else $error("bus address changed after sampling");
    AST_PIN_TURN: assert property (@(posedge CLK_SYS) disable iff (SRST) // [RL15]
        !live |=> PIN_PULLUP_EN && !ADDR_STRAP0_ANALOG_SEL_OE && !ADDR_STRAP1_GOOD_OUT_OE)
        else $error("strap pin driven before sampling finished");
    AST_MUX_SEL: assert property (@(posedge CLK_SYS) disable iff (SRST) // [RL7]
        live |=> ADDR_STRAP0_ANALOG_SEL_OE && ADDR_STRAP0_ANALOG_SEL_OUT == $past(MEAS_CURRENT))
        else $error("analog select does not follow the measurement type");
    AST_FLT_DRV: assert property (@(posedge CLK_SYS) disable iff (SRST) // [RL8]
        live && |(stat[5:0] & group) |=> FAULT_N_OE)
        else $error("fault line not pulled for a group fault");
    // a released enable pin reads high through its board pull-up; push-pull pins drive once live
    AST_GRP_OFF: assert property (@(posedge CLK_SYS) disable iff (SRST) // [RL9]
        !fault_dg |=> (en_req & group) == 6'h00
            ##1 (((~SUPPLY_ENABLE_OE | SUPPLY_ENABLE_OUT) ~^ mode[5:0]) & group) == 6'h00)
        else $error("group supply kept on while fault line low");
    AST_RST_REL: assert property (@(posedge CLK_SYS) // [RL10]
        SRST |=> !FAULT_N_OE && !ALERT_N_OE && PIN_PULLUP_EN)
        else $error("line driven during reset");
    AST_CTL_OFF: assert property (@(posedge CLK_SYS) disable iff (SRST) // [RL12]
        ctrl[`SPSC_CTRL_CTLUSE] && ctl_dg != ctrl[`SPSC_CTRL_CTLAH] |-> en_req == 6'h00)
        else $error("supply enabled while control input is off");
    AST_PG: assert property (@(posedge CLK_SYS) disable iff (SRST) // [RL13]
        live && !pg_cond |=> !ADDR_STRAP1_GOOD_OUT_OUT)
        else $error("power good high with an enabled supply below threshold");
    AST_ALERT: assert property (@(posedge CLK_SYS) disable iff (SRST) // [RL14]
        live && ALERT_REQ |=> ALERT_N_OE && !ALERT_N_OUT)
        else $error("alert not pulled low");
    CVR_LIVE: cover property (@(posedge CLK_SYS) disable iff (SRST) $rose(live));
    CVR_FLT: cover property (@(posedge CLK_SYS) disable iff (SRST) $rose(FAULT_N_OE));
    CVR_IRQ: cover property (@(posedge CLK_SYS) disable iff (SRST) $rose(IRQ));
endmodule

// *** spsc_defs.svh ***
// constants of the supply control pin logic
// Contract
// (RL1) a channel's margin drive is released (not driven) whenever margining is off for that channel.
// (RL2) a margin drive set to full duty stays high all the time with no low phase.
// (RL3) each supply enable output has a selectable active level, high or low.
// (RL4) each supply enable output is selectable as open-drain or push-pull.
// (RL5) at power-up both address straps are sampled as inputs and latched as the bus address.
// (RL6) after sampling, the first strap pin becomes the analog multiplexer select output.
// (RL7) the multiplexer select is low for voltage and high for current measurement.
// (RL8) the open-drain fault line is pulled low while any group supply is shut down by a fault.
// (RL9) when anyone pulls the fault line low, every supply of the global group is shut down.
// (RL10) the fault line is released while reset is held and during power-up.
// (RL11) the fault line and the control input pass a deglitch filter of the filter time.
// (RL12) the control input enables the supplies with a selectable active level.
// (RL13) after power-up the second strap pin is power-good, high once every enabled supply is good.
// (RL14) the alert output is active-low open-drain: it pulls low or releases.
// (RL15) during power-up and reset the pins float with pull-ups, then become inputs or outputs.
// (RL16) enable and margin logic is six identical independent channels with their own settings.
`ifndef SPSC_DEFS_SVH
`define SPSC_DEFS_SVH
// -----------------------------------------------
// sizes and timing
// -----------------------------------------------
`define SPSC_NCH 6
`define SPSC_CLK_MHZ 250
`define SPSC_DGLT_NS 50000
`define SPSC_DGLT_CYC (`SPSC_DGLT_NS * `SPSC_CLK_MHZ / 1000)
`define SPSC_PWM_HZ 62500
`define SPSC_PWM_STEPS 64
`define SPSC_PWM_DIV (`SPSC_CLK_MHZ * 1000000 / (`SPSC_PWM_HZ * `SPSC_PWM_STEPS))
`define SPSC_STRAP_CYC 4
`define SPSC_DUTY_FULL 7'h40
// -----------------------------------------------
// register offsets
// -----------------------------------------------
`define SPSC_OFF_CTRL 8'h00
`define SPSC_OFF_GROUP 8'h04
`define SPSC_OFF_STAT 8'h08
`define SPSC_OFF_MASK 8'h0c
`define SPSC_OFF_MODE 8'h10
`define SPSC_OFF_DUTY0 8'h14
`define SPSC_OFF_PINS 8'h2c
// -----------------------------------------------
// fields and reset values
// -----------------------------------------------
`define SPSC_CTRL_CTLAH 8
`define SPSC_CTRL_CTLUSE 9
`define SPSC_MODE_AH 0
`define SPSC_MODE_OD 8
`define SPSC_MODE_MEN 16
`define SPSC_STAT_GRP 6
`define SPSC_STAT_CTL 7
`define SPSC_RST_CTRL 10'h300
`define SPSC_RST_MODE 22'h00003f
`endif

// *** spsc_pkg.sv ***
// types and shared functions of the supply control pin logic
package spsc_pkg;
    typedef enum logic [1:0] {SPSC_HOLD, SPSC_SAMPLE, SPSC_LIVE} spsc_phase_t;
    // level of a signal that is "on", given its active level
    function automatic logic spsc_lvl(input logic on, input logic act_high);
        return ~(on ^ act_high);
    endfunction
endpackage

// *** spsc_dglt.sv ***
// two-flop synchroniser and deglitch filter for one pin
`timescale 1ns/100ps
`include "spsc_defs.svh"
module spsc_dglt
    import spsc_pkg::*;
    #(parameter int unsigned DG = 12500)
    (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pin and filtered level
    input wire logic pin,
    output logic lvl
    );
    localparam int CW = $clog2(DG + 1);
    logic meta;
    logic sync;
    logic filt;
    logic [CW-1:0] cnt;
    logic next_filt;
    logic [CW-1:0] next_cnt;

    // -----------------------------------------------
    // filter: a new level must hold DG cycles
    // -----------------------------------------------
    always_comb begin
        next_filt = filt;
        next_cnt = '0;
        if (sync != filt) begin
            if (cnt == CW'(DG - 1)) begin
                next_filt = sync; // [RL11]
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    // released lines idle high through the pull-ups
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= 1'b1;
            sync <= 1'b1;
            filt <= 1'b1;
            cnt <= '0;
        end else begin
            meta <= pin;
            sync <= meta;
            filt <= next_filt;
            cnt <= next_cnt;
        end
    end
    assign lvl = filt;

    AST_DGLT_HOLD: assert property (@(posedge clk) disable iff (srst) // [RL11]
        $changed(filt) |-> $past(cnt) == CW'(DG - 1))
        else $error("filtered level changed before the filter time");
    CVR_DGLT: cover property (@(posedge clk) disable iff (srst) $fell(filt));
endmodule

// *** spsc_chan.sv ***
// one supply channel: enable pin and margin drive
`timescale 1ns/100ps
`include "spsc_defs.svh"
module spsc_chan
    import spsc_pkg::*;
    (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic live,
    input wire logic en_req,
    input wire logic act_high,
    input wire logic open_drain,
    input wire logic margin_en,
    input wire logic [6:0] duty,
    input wire logic [5:0] step,
    // pins
    output logic en_out,
    output logic en_oe,
    output logic mg_out,
    output logic mg_oe
    );
    logic lvl;
    logic next_en_out;
    logic next_en_oe;
    logic next_mg_out;
    logic next_mg_oe;

    // -----------------------------------------------
    // pin drive
    // -----------------------------------------------
    always_comb begin
        lvl = spsc_lvl(en_req, act_high); // [RL3]
        next_en_out = 1'b0;
        next_en_oe = 1'b0;
        next_mg_out = 1'b0;
        next_mg_oe = 1'b0;
        if (live) begin
            next_en_oe = open_drain ? ~lvl : 1'b1; // [RL4]
            next_en_out = open_drain ? 1'b0 : lvl; // [RL4]
            next_mg_oe = margin_en; // [RL1]
            // duty 64 beats every step value, so full duty never goes low
            next_mg_out = margin_en && ({1'b0, step} < duty); // [RL2]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            en_out <= 1'b0;
            en_oe <= 1'b0;
            mg_out <= 1'b0;
            mg_oe <= 1'b0;
        end else begin
            en_out <= next_en_out;
            en_oe <= next_en_oe;
            mg_out <= next_mg_out;
            mg_oe <= next_mg_oe;
        end
    end

    AST_MG_HIZ: assert property (@(posedge clk) disable iff (srst) // [RL1]
        !margin_en |=> !mg_oe && !mg_out)
        else $error("margin drive active while margining is off");
    AST_MG_FULL: assert property (@(posedge clk) disable iff (srst) // [RL2]
        live && margin_en && duty >= `SPSC_DUTY_FULL |=> mg_oe && mg_out)
        else $error("full duty margin drive went low");
    AST_EN_PP: assert property (@(posedge clk) disable iff (srst) // [RL3]
        live && !open_drain |=> en_oe && (en_out == ($past(en_req) == $past(act_high))))
        else $error("push-pull enable level wrong");
    AST_EN_OD: assert property (@(posedge clk) disable iff (srst) // [RL4]
        live && open_drain |=> !en_out && (en_oe == ($past(en_req) != $past(act_high))))
        else $error("open-drain enable drive wrong");
endmodule

// *** spsc_far_model.sv ***
// far side model: pulled-up fault and alert lines, a peer, strap resistors
`timescale 1ns/100ps
module spsc_far_model (
    // device drives
    input wire logic fault_oe,
    input wire logic fault_out,
    input wire logic alert_oe,
    input wire logic alert_out,
    input wire logic s0_out,
    input wire logic s0_oe,
    input wire logic s1_out,
    input wire logic s1_oe,
    // peer device and board straps
    input wire logic peer_pull,
    input wire logic [1:0] strap_res,
    // resolved lines
    output logic fault_n,
    output logic alert_n,
    output logic s0_in,
    output logic s1_in
    );
    // --------------------------------
    // line resolution
    // --------------------------------
    // wired-and with pull-up: a peer pulling low reaches every device on the line
    assign fault_n = ~(peer_pull | (fault_oe & ~fault_out));
    assign alert_n = ~(alert_oe & ~alert_out);
    // a released strap shows its board resistor, not the last driven level
    assign s0_in = s0_oe ? s0_out : strap_res[0];
    assign s1_in = s1_oe ? s1_out : strap_res[1];
endmodule

// *** supply_control_pin_logic_tb_top.sv ***
// self-checking bench of the supply control pin logic
`timescale 1ns/100ps
`include "spsc_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module supply_control_pin_logic_tb_top;
    // --------------------------------
    // signals and instances
    // --------------------------------
    // short filter keeps the run brief
    localparam int unsigned DG = 8;
    logic CLK_SYS = 1'b0;
    logic SRST = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0, rd = 1'b0, meas = 1'b0, areq = 1'b0, ctl = 1'b1, peer = 1'b0, rd_seen = 1'b0;
    logic [5:0] cf = 6'h00, pg = 6'h00, ah, od, men, en_out, en_oe, mg_out, mg_oe;
    logic [1:0] sres = 2'h0, bus_addr;
    logic [31:0] rdata, exp_v;
    logic irq, f_out, f_oe, a_out, a_oe, s0o, s0e, s1o, s1e, pull_en, fault_n, alert_n, s0_in, s1_in;
    logic [31:0] exp_q[$];
    int fail_count = 0;
    int n_tests = 0;
    int k;
    always #2 CLK_SYS = ~CLK_SYS;
    spsc_top #(.DGLT_CYC(DG)) DUT (.CLK_SYS(CLK_SYS), .SRST(SRST), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq), .CHAN_FAULT(cf), .CHAN_ABOVE_PG_ON(pg),
        .MEAS_CURRENT(meas), .ALERT_REQ(areq), .SUPPLY_ENABLE_OUT(en_out), .SUPPLY_ENABLE_OE(en_oe),
        .MARGIN_DRIVE_OUT(mg_out), .MARGIN_DRIVE_OE(mg_oe), .FAULT_N_IN(fault_n), .FAULT_N_OUT(f_out),
        .FAULT_N_OE(f_oe), .CONTROL_IN(ctl), .ALERT_N_OUT(a_out), .ALERT_N_OE(a_oe),
        .ADDR_STRAP0_ANALOG_SEL_IN(s0_in), .ADDR_STRAP0_ANALOG_SEL_OUT(s0o), .ADDR_STRAP0_ANALOG_SEL_OE(s0e),
        .ADDR_STRAP1_GOOD_OUT_IN(s1_in), .ADDR_STRAP1_GOOD_OUT_OUT(s1o), .ADDR_STRAP1_GOOD_OUT_OE(s1e),
        .BUS_ADDR(bus_addr), .PIN_PULLUP_EN(pull_en));
    spsc_far_model FAR (.fault_oe(f_oe), .fault_out(f_out), .alert_oe(a_oe), .alert_out(a_out),
        .s0_out(s0o), .s0_oe(s0e), .s1_out(s1o), .s1_oe(s1e), .peer_pull(peer), .strap_res(sres),
        .fault_n(fault_n), .alert_n(alert_n), .s0_in(s0_in), .s1_in(s1_in));
    // --------------------------------
    // tasks
    // --------------------------------
    // returns just after an edge so that its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge CLK_SYS);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_SYS);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge CLK_SYS);
        rd <= 1'b0;
    endtask
    task automatic chk_pins(input logic on);
        logic lvl;
        for (int i = 0; i < `SPSC_NCH; i++) begin
            lvl = on ~^ ah[i];
            `CHK("enable pin", {od[i] ? ~lvl : 1'b1, lvl}, {en_oe[i], en_oe[i] ? en_out[i] : 1'b1})
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge CLK_SYS) begin
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            `CHK("read data", exp_v, rdata)
        end
        rd_seen <= rd;
    end
    initial begin
        cyc(12000);
        fail_count++;
        finish_test();
    end
    // --------------------------------
    // scenarios
    // --------------------------------
    initial begin
        void'($urandom(47659));
        sres = 2'($urandom);
        {ah, od, men} = 18'($urandom);
        k = $urandom_range(5, 0);
        men[k] = 1'b1;
        cyc(20);
        SRST <= 1'b0;
        cyc(10);
        `CHK("straps", {sres, 3'b110}, {bus_addr, s0e, s1e, pull_en})
        rd_reg(`SPSC_OFF_CTRL, 32'(`SPSC_RST_CTRL));
        rd_reg(`SPSC_OFF_MODE, 32'(`SPSC_RST_MODE));
        wr_reg(`SPSC_OFF_PINS, 32'hff);
        rd_reg(`SPSC_OFF_PINS, {26'h0, 4'hb, sres});
        rd_reg(8'h40, 32'h0);
        for (int m = 0; m < 2; m++) begin
            meas <= m[0];
            cyc(3);
            `CHK("analog select", m[0], s0_in)
        end
        wr_reg(`SPSC_OFF_MODE, {10'h0, men, 2'h0, od, 2'h0, ah});
        for (int i = 0; i < `SPSC_NCH; i++) begin
            wr_reg(8'(`SPSC_OFF_DUTY0 + 4 * i), 32'(`SPSC_DUTY_FULL));
        end
        rd_reg(8'(`SPSC_OFF_DUTY0 + 4 * k), 32'(`SPSC_DUTY_FULL));
        wr_reg(`SPSC_OFF_CTRL, 32'h33f);
        cyc(3);
        chk_pins(1'b1);
        // one whole drive period: full duty must never show a low phase
        for (int t = 0; t < 4000; t++) begin
            `CHK("margin drive", {men, men}, {mg_oe, mg_out})
            cyc(1);
        end
        areq <= 1'b1;
        pg <= 6'h3f;
        cyc(3);
        `CHK("alert and good", 3'b011, {alert_n, a_oe, s1_in})
        areq <= 1'b0;
        pg[k] <= 1'b0;
        cyc(3);
        `CHK("alert and good", 3'b100, {alert_n, a_oe, s1_in})
        pg <= 6'h3f;
        ctl <= 1'b0;
        cyc(DG - 4);
        ctl <= 1'b1;
        cyc(20);
        chk_pins(1'b1);
        rd_reg(`SPSC_OFF_STAT, 32'h0);
        ctl <= 1'b0;
        cyc(20);
        chk_pins(1'b0);
        rd_reg(`SPSC_OFF_STAT, 32'h80);
        wr_reg(`SPSC_OFF_STAT, 32'h80);
        wr_reg(`SPSC_OFF_CTRL, 32'h23f);
        rd_reg(`SPSC_OFF_STAT, 32'h0);
        cyc(3);
        chk_pins(1'b1);
        peer <= 1'b1;
        cyc(3);
        peer <= 1'b0;
        cyc(20);
        rd_reg(`SPSC_OFF_STAT, 32'h0);
        wr_reg(`SPSC_OFF_GROUP, 32'h3f);
        wr_reg(`SPSC_OFF_MASK, 32'hff);
        cf[k] <= 1'b1;
        cyc(1);
        cf[k] <= 1'b0;
        cyc(2);
        `CHK("fault drive", 2'b11, {f_oe, irq})
        cyc(16);
        chk_pins(1'b0);
        rd_reg(`SPSC_OFF_STAT, 32'h40 | (32'h1 << k));
        wr_reg(`SPSC_OFF_MASK, 32'h0);
        cyc(3);
        `CHK("masked irq", 1'b0, irq)
        SRST <= 1'b1;
        cyc(3);
        `CHK("reset pins", 4'b0001, {f_oe, s0e, s1e, pull_en})
        finish_test();
    end
endmodule
